// [hdl/program_write_guard.sv]
// program write guard: ceiling set, write block and break reason
`timescale 1ns/100ps
`include "guard_map.svh"
module program_write_guard
(
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        set_limit,
    input  wire logic [15:0]                 limit_in,
    output logic                             set_error,
    output logic [15:0]                      limit_rd,
    input  wire logic                        exec_mode,
    input  wire guard_pkg::wr_req_s          wr_req,
    input  wire logic                        data_bp_hit,
    input  wire logic                        instr_done,
    output logic                             wr_allow,
    output guard_pkg::brk_s                  brk,
    output guard_pkg::break_reason_e         break_reason_query
);
    import guard_pkg::*;

    typedef enum logic [1:0] {st_run, st_extra, st_halt} brk_st_e;

    logic [14:0]   ceil_q, ceil_d;     // requested ceiling, rounded
    logic [14:0]   cmp_q, cmp_d;       // value held by comparators
    logic          exec_q, exec_d;
    logic          err_q, err_d;
    brk_st_e       st_q, st_d;
    break_reason_e rsn_q, rsn_d;
    logic          hit, exempt, viol;

    function automatic logic [14:0] round_up(input logic [15:0] a);
        round_up = {a[`GUARD_BLK_MSB:`GUARD_BLK_LSB], `GUARD_BLK_FILL};
    endfunction

    // ceiling store; zero stays zero so no block is guarded
    always_comb
    begin
        ceil_d = ceil_q;
        err_d  = 1'b0;
        if (set_limit)
        begin
            if (limit_in > `GUARD_USER_MAX)
                err_d = 1'b1;
            else if (limit_in == `GUARD_LIMIT_OFF)
                ceil_d = `GUARD_CEIL_RST;
            else
                ceil_d = round_up(limit_in);
        end
        exec_d = exec_mode;
        // comparator follows the ceiling only outside execution, so the
        // value of the last interrogation cycle is the one that guards;
        // no unguarded first cycle, and edits during a run wait for next
        cmp_d = exec_mode ? cmp_q : ceil_q;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ceil_q <= `GUARD_CEIL_RST;
            cmp_q  <= `GUARD_CEIL_RST;
            exec_q <= 1'b0;
            err_q  <= 1'b0;
        end
        else
        begin
            ceil_q <= ceil_d;
            cmp_q  <= cmp_d;
            exec_q <= exec_d;
            err_q  <= err_d;
        end
    end

    assign set_error = err_q;
    assign limit_rd  = {1'b0, ceil_q};

    // comparator is loaded before entry, so the first cycle is guarded
    guard_cmp u_cmp
    (
        .addr     (wr_req.addr),
        .ceil_blk (cmp_q[`GUARD_BLK_MSB:`GUARD_BLK_LSB]),
        .ceil_on  (cmp_q != `GUARD_CEIL_RST),
        .strobe   (wr_req.valid),
        .exec     (exec_mode),
        .hit      (hit)
    );

    assign exempt = wr_req.monitor
        && (wr_req.addr >= `GUARD_EXEMPT_LO)
        && (wr_req.addr <= `GUARD_EXEMPT_HI);
    assign viol   = hit && !exempt;
    // combinational block, independent of break state machine
    assign wr_allow = wr_req.valid && !viol;

    // break sequencing per instruction completion
    always_comb
    begin
        st_d  = st_q;
        rsn_d = rsn_q;
        case (st_q)
            st_run:
            begin
                if (viol && data_bp_hit)
                begin
                    st_d  = st_halt;
                    rsn_d = reason_guard;
                end
                else if (viol)
                begin
                    st_d  = st_extra;
                    rsn_d = reason_guard;
                end
                // a breakpoint seen outside execution must not set a reason
                else if (data_bp_hit && exec_mode)
                begin
                    st_d  = st_halt;
                    rsn_d = reason_data;
                end
            end
            st_extra:
                if (instr_done)
                    st_d = st_halt;
            st_halt:
                if (!exec_mode)
                    st_d = st_run;
            default:
                st_d = st_run;
        endcase
        if (!exec_mode && st_q != st_halt)
            st_d = st_run;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q  <= st_run;
            rsn_q <= reason_none;
        end
        else
        begin
            st_q  <= st_d;
            rsn_q <= rsn_d;
        end
    end

    assign brk.stop  = (st_q == st_halt);
    assign brk.extra = (st_q == st_extra);
    assign brk.reason = rsn_q;
    assign break_reason_query = rsn_q;

    // write path: a violation never reaches memory
    chk_blocked_write: assert property
        (@(posedge clk) disable iff (!nrst)
        viol |-> !wr_allow)
        else $error("protected write let through");

    chk_zero_ceiling: assert property
        (@(posedge clk) disable iff (!nrst)
        cmp_q == `GUARD_CEIL_RST |-> !hit)
        else $error("guard with zero ceiling");

    chk_monitor_exempt: assert property
        (@(posedge clk) disable iff (!nrst)
        wr_req.valid && exempt |-> wr_allow)
        else $error("monitor write blocked");

    // ceiling store and its read-back
    chk_round_up: assert property
        (@(posedge clk) disable iff (!nrst)
        set_limit && limit_in != `GUARD_LIMIT_OFF
        && limit_in <= `GUARD_USER_MAX
        |=> ceil_q[`GUARD_BLK_LSB-1:0] == `GUARD_BLK_FILL)
        else $error("ceiling not rounded");

    chk_reject_keep: assert property
        (@(posedge clk) disable iff (!nrst)
        set_limit && limit_in > `GUARD_USER_MAX
        |=> err_q && $stable(ceil_q))
        else $error("bad limit accepted");

    chk_readback_rounded: assert property
        (@(posedge clk) disable iff (!nrst)
        limit_rd[`GUARD_USER_BIT] == 1'b0
        && (limit_rd == `GUARD_LIMIT_OFF
        || limit_rd[`GUARD_BLK_LSB-1:0] == `GUARD_BLK_FILL))
        else $error("readback not rounded");

    // comparator load: frozen in execution, tracking outside it
    chk_load_entry: assert property
        (@(posedge clk) disable iff (!nrst)
        exec_q && exec_mode |=> $stable(cmp_q))
        else $error("comparator reloaded in execution");

    chk_load_idle: assert property
        (@(posedge clk) disable iff (!nrst)
        !exec_mode |=> cmp_q == $past(ceil_q))
        else $error("comparator not loaded before entry");

    // break sequencing
    chk_data_reason: assert property
        (@(posedge clk) disable iff (!nrst)
        st_q == st_run && data_bp_hit && !viol && exec_mode
        |=> brk.stop && rsn_q == reason_data)
        else $error("data break reason wrong");

    chk_halt_holds: assert property
        (@(posedge clk) disable iff (!nrst)
        brk.stop && exec_mode |=> brk.stop)
        else $error("halt released in execution");

    chk_extra_once: assert property
        (@(posedge clk) disable iff (!nrst)
        st_q == st_run && viol && !data_bp_hit
        |=> brk.extra && !brk.stop && rsn_q == reason_guard)
        else $error("extra step not granted");

    chk_extra_ends: assert property
        (@(posedge clk) disable iff (!nrst)
        brk.extra && instr_done && exec_mode |=> brk.stop)
        else $error("extra step not ended");

    chk_guard_reason: assert property
        (@(posedge clk) disable iff (!nrst)
        st_q == st_run && viol && data_bp_hit
        |=> brk.stop && !brk.extra && rsn_q == reason_guard)
        else $error("guarded reason wrong");

    cov_guard_break: cover property (@(posedge clk) viol && !data_bp_hit);
    cov_data_break: cover property (@(posedge clk) data_bp_hit && !viol);
    cov_both_break: cover property (@(posedge clk) viol && data_bp_hit);
    cov_reject: cover property (@(posedge clk) set_error);
    cov_first_cycle: cover property
        (@(posedge clk) exec_mode && !exec_q && viol);
endmodule // program_write_guard

// [hdl/guard_map.svh]
// register-free constants for the program write guard
`ifndef GUARD_MAP_SVH
`define GUARD_MAP_SVH
`define GUARD_ADDR_W     16
`define GUARD_USER_MAX   16'h7FFF
`define GUARD_BLK_LSB    8
`define GUARD_BLK_MSB    14
`define GUARD_BLK_FILL   8'hFF
`define GUARD_CEIL_RST   15'h0000
`define GUARD_EXEMPT_LO  16'h0003
`define GUARD_EXEMPT_HI  16'h0005
`define GUARD_LIMIT_OFF  16'h0000
`define GUARD_USER_BIT   15
`endif

// [hdl/guard_pkg.sv]
// types shared by the program write guard
package guard_pkg;
    typedef enum logic [1:0] {
        reason_none,
        reason_data,
        reason_guard
    } break_reason_e;

    typedef struct packed {
        logic        valid;
        logic        monitor;
        logic [15:0] addr;
    } wr_req_s;

    typedef struct packed {
        logic          stop;
        logic          extra;
        break_reason_e reason;
    } brk_s;
endpackage

// [hdl/guard_cmp.sv]
// block-number comparator for protected writes
`timescale 1ns/100ps
`include "guard_map.svh"
module guard_cmp
(
    input  wire logic [15:0] addr,
    input  wire logic [6:0]  ceil_blk,
    input  wire logic        ceil_on,
    input  wire logic        strobe,
    input  wire logic        exec,
    output logic             hit
);
    // block compare plus user-space bit 15; low byte never matters at 256-byte grain
    always_comb
    begin
        hit = strobe && exec && ceil_on
            && (addr[`GUARD_USER_BIT] == 1'b0)
            && (addr[`GUARD_BLK_MSB:`GUARD_BLK_LSB] <= ceil_blk);
    end
endmodule // guard_cmp

// [testbench/core_model.sv]
// processor core model issuing external writes to the guard
`timescale 1ns/100ps
module core_model
(
    input  wire logic          clk,
    input  wire logic          wr_allow,
    output logic               exec_mode,
    output guard_pkg::wr_req_s wr_req,
    output logic               data_bp_hit,
    output logic               instr_done
);
    import guard_pkg::*;
    // idle core in interrogation mode
    initial
    begin
        exec_mode = 1'b0;
        wr_req = '0;
        data_bp_hit = 1'b0;
        instr_done = 1'b0;
    end
    // switch mode one edge after the last request was released; entry
    // returns at once so the next write lands in the first run cycle
    task automatic mode(input logic on);
        @(posedge clk);
        #1;
        exec_mode = on;
        if (!on)
        begin
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    // one write; released address inverted so stale values never match
    task automatic write(input logic [15:0] a, input logic m,
                         input logic bp, output logic ok);
        wr_req = '{1'b1, m, a};
        data_bp_hit = bp;
        #1 ok = wr_allow;
        @(posedge clk);
        #1;
        wr_req = '{1'b0, 1'b0, ~a};
        data_bp_hit = 1'b0;
    endtask
    // one instruction completes
    task automatic step();
        instr_done = 1'b1;
        @(posedge clk);
        #1;
        instr_done = 1'b0;
    endtask
endmodule // core_model

// [testbench/tb_program_write_guard.sv]
// self-checking bench for the program write guard
`timescale 1ns/100ps
module tb_program_write_guard;
    import guard_pkg::*;
    logic          clk, nrst, set_limit, set_error, exec_mode;
    logic          data_bp_hit, instr_done, wr_allow, ok, v;
    logic [15:0]   limit_in, limit_rd, ceil;
    wr_req_s       wr_req;
    brk_s          brk;
    break_reason_e break_reason_query;
    int            n_errors, n_checks;

    program_write_guard i_dut (.clk(clk), .nrst(nrst),
        .set_limit(set_limit), .limit_in(limit_in), .set_error(set_error),
        .limit_rd(limit_rd), .exec_mode(exec_mode), .wr_req(wr_req),
        .data_bp_hit(data_bp_hit), .instr_done(instr_done),
        .wr_allow(wr_allow), .brk(brk),
        .break_reason_query(break_reason_query));
    core_model i_core (.clk(clk), .wr_allow(wr_allow),
        .exec_mode(exec_mode), .wr_req(wr_req),
        .data_bp_hit(data_bp_hit), .instr_done(instr_done));

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request a ceiling; model rounds up, rejects above user space
    task automatic setlim(input logic [15:0] x);
        set_limit = 1'b1;
        limit_in = x;
        @(posedge clk);
        #1;
        set_limit = 1'b0;
        if (x <= 16'h7FFF)
            ceil = (x == 16'h0000) ? 16'h0000 : (x | 16'h00FF);
        check("set_error", x > 16'h7FFF, set_error);
        check("limit_rd", ceil, limit_rd);
        // idle edge, so the strobe never falls and rises in one step
        @(posedge clk);
        #1;
        check("error pulse", 0, set_error);
    endtask
    // one write in each mode, then the break sequence it causes
    task automatic trial(input logic [15:0] lim, input logic [15:0] a,
                         input logic m, input logic bp);
        setlim(lim);
        i_core.write(a, m, 1'b0, ok);
        check("idle allow", 1, ok);
        i_core.mode(1'b1);
        v = ceil != 0 && a <= ceil && !(m && a >= 3 && a <= 5);
        i_core.write(a, m, bp, ok);
        check("allow", !v, ok);
        check("extra", v && !bp, brk.extra);
        check("stop", bp, brk.stop);
        if (v || bp)
            check("reason", v ? reason_guard : reason_data, brk.reason);
        if (v && !bp)
        begin
            i_core.step();
            check("stop late", 1, brk.stop);
        end
        i_core.mode(1'b0);
        check("resume", 0, brk.stop);
        if (v || bp)
            check("query", v ? reason_guard : reason_data,
                  break_reason_query);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // watchdog far beyond the 150 or so cycles needed
    initial
    begin
        #20000;
        n_errors++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(32'h74436A23));
        nrst = 1'b0;
        set_limit = 1'b0;
        limit_in = 16'h0000;
        ceil = 16'h0000;
        repeat (4) @(posedge clk);
        #1 nrst = 1'b1;
        check("rst limit", 0, limit_rd);
        setlim(16'h0001);
        setlim(16'h1F10);
        setlim(16'h7FFF);
        setlim(16'h8000);
        setlim(16'hFFFF);
        setlim(16'h0000);
        $display("limit test done");
        trial(16'h1F10, 16'h1FFF, 1'b0, 1'b0);
        trial(16'h1F10, 16'h2000, 1'b0, 1'b0);
        trial(16'h1F10, 16'h0004, 1'b1, 1'b0);
        trial(16'h1F10, 16'h0004, 1'b0, 1'b1);
        trial(16'h0000, 16'h0100, 1'b0, 1'b1);
        trial(16'h0000, 16'h0000, 1'b0, 1'b0);
        repeat (8)
            trial(16'($urandom_range(16'h7FFF)),
                  16'($urandom_range(16'h7FFF)),
                  1'($urandom_range(1)), 1'($urandom_range(1)));
        $display("write test done");
        nrst = 1'b0;
        @(posedge clk);
        #1 nrst = 1'b1;
        check("rst limit", 0, limit_rd);
        check("rst query", 0, break_reason_query);
        check("rst stop", 0, brk.stop);
        $display("reset test done");
        end_of_test();
    end
endmodule // tb_program_write_guard
